// file: design/atm_pkg.sv
// shared constants and types for the transmit channel slot mapper
package atm_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ATM_ADDR_CH_ONE = 8'h1e;
  localparam logic [7:0] ATM_ADDR_CH_TWO = 8'h1f;
  localparam logic [7:0] ATM_RST_CH_ONE = 8'h20;
  localparam logic [7:0] ATM_RST_CH_TWO = 8'h21;
  localparam int ATM_ENA_BIT = 5;
  localparam int ATM_SLOT_MSB = 4;
  localparam int ATM_SLOT_LSB = 0;
  localparam int ATM_CFG_BITS = 6;
  localparam logic [1:0] ATM_RSVD_VAL = 2'h0;
  localparam int ATM_NUM_CH = 2;
  // ---------------------------------------------------------------
  // framing
  // ---------------------------------------------------------------
  localparam logic [5:0] ATM_TDM_SLOTS = 6'h20;
  localparam logic [5:0] ATM_HALF_SLOTS = 6'h10;
  localparam int ATM_WORD_BITS = 32;
  localparam int ATM_SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    ATM_FMT_TDM,
    ATM_FMT_I2S,
    ATM_FMT_LJ
  } atm_fmt_t;
endpackage

// file: design/atm_slot_mapper.sv
// transmit channel slot mapper for the primary audio serial port
// How it works
// [R1] channel one slot is tri-stated when its enable is 0, unless channel two is enabled in it on the same pin, else carries capture channel 1.
// [R2] channel two slot is tri-stated when its enable is 0, else carries capture channel 2, unless channel one is enabled in it on the same pin.
// [R3] each channel has a five-bit slot field; in tdm value n selects slot n of 0..31.
// [R4] in i2s or left-justified framing values 0..15 select left-half slots 0..15.
// [R5] in i2s or left-justified framing values 16..31 select right-half slots 0..15.
// [R6] channel one config byte resets to 0x20, enabled in slot 0.
// [R7] channel two config byte resets to 0x21, enabled in slot 1.
// [R8] bits 7 and 6 of each config byte are reserved, read zero, and take only zero.
// [R9] a per-channel pin select routes the channel to the primary pin at 0, secondary at 1.
// [R10] cycles in no channel's slot on a pin drive zero when fill is 0 and go high-impedance when 1.
`timescale 1ns/100ps
module atm_slot_mapper #(
  parameter int WORD_BITS = atm_pkg::ATM_WORD_BITS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic tx_chan_one_pin_select,
  input wire logic tx_chan_two_pin_select,
  input wire logic tx_unused_cycle_fill,
  input wire atm_pkg::atm_fmt_t frame_format,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [WORD_BITS-1:0] chan_one_sample,
  input wire logic [WORD_BITS-1:0] chan_two_sample,
  input wire logic bclk,
  input wire logic fsync,
  output logic primary_serial_out,
  output logic primary_serial_oe_n,
  output logic secondary_serial_out,
  output logic secondary_serial_oe_n
);
  import atm_pkg::*;

  localparam int CW = $clog2(WORD_BITS);

  initial begin
    if (WORD_BITS < 16 || WORD_BITS > 32) begin
      $error("WORD_BITS must lie between 16 and 32");
    end
  end

  // ---------------------------------------------------------------
  // register file (core domain)
  // ---------------------------------------------------------------
  logic [ATM_CFG_BITS-1:0] cfg_r [ATM_NUM_CH];
  wire hit_one = reg_addr == ATM_ADDR_CH_ONE;
  wire hit_two = reg_addr == ATM_ADDR_CH_TWO;
  wire [7:0] rd_mux = hit_one ? {ATM_RSVD_VAL, cfg_r[0]} :
                      hit_two ? {ATM_RSVD_VAL, cfg_r[1]} : 8'h00; // R8

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r[0] <= ATM_RST_CH_ONE[ATM_CFG_BITS-1:0]; // R6
      cfg_r[1] <= ATM_RST_CH_TWO[ATM_CFG_BITS-1:0]; // R7
    end else begin
      // reserved bits are simply dropped on write
      if (reg_wr && hit_one) cfg_r[0] <= reg_wdata[ATM_CFG_BITS-1:0]; // R8
      if (reg_wr && hit_two) cfg_r[1] <= reg_wdata[ATM_CFG_BITS-1:0]; // R8
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // sample and config bundle, toggle handshake to the link
  // ---------------------------------------------------------------
  // config travels with each sample so the link never sees a torn word
  logic [WORD_BITS-1:0] hold_smp_r [ATM_NUM_CH];
  logic [ATM_CFG_BITS-1:0] hold_cfg_r [ATM_NUM_CH];
  logic [ATM_NUM_CH-1:0] hold_sel_r;
  logic hold_fill_r;
  atm_fmt_t hold_fmt_r;
  logic req_r, ack_s1_r, ack_s2_r, lk_ack_r;
  assign sample_ready = req_r == ack_s2_r;
  wire accept = sample_valid && sample_ready;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_r <= 1'b0;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= lk_ack_r;
      ack_s2_r <= ack_s1_r;
      if (accept) req_r <= ~req_r;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_smp_r[0] <= '0;
      hold_smp_r[1] <= '0;
      hold_cfg_r[0] <= ATM_RST_CH_ONE[ATM_CFG_BITS-1:0];
      hold_cfg_r[1] <= ATM_RST_CH_TWO[ATM_CFG_BITS-1:0];
      hold_sel_r <= '0;
      hold_fill_r <= 1'b0;
      hold_fmt_r <= ATM_FMT_TDM;
    end else if (accept) begin
      hold_smp_r[0] <= chan_one_sample;
      hold_smp_r[1] <= chan_two_sample;
      hold_cfg_r[0] <= cfg_r[0];
      hold_cfg_r[1] <= cfg_r[1];
      hold_sel_r <= {tx_chan_two_pin_select, tx_chan_one_pin_select};
      hold_fill_r <= tx_unused_cycle_fill;
      hold_fmt_r <= frame_format;
    end
  end

  // ---------------------------------------------------------------
  // link domain reset and synchronisers
  // ---------------------------------------------------------------
  logic lrst_s1_r, lrst_n_r;
  always_ff @(posedge bclk or negedge rst_n) begin
    if (!rst_n) begin
      lrst_s1_r <= 1'b0;
      lrst_n_r <= 1'b0;
    end else begin
      lrst_s1_r <= 1'b1;
      lrst_n_r <= lrst_s1_r;
    end
  end

  logic req_s1_r, req_s2_r, fs_s1_r, fs_s2_r, fs_d_r;
  always_ff @(posedge bclk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      lk_ack_r <= 1'b0;
      fs_s1_r <= 1'b0;
      fs_s2_r <= 1'b0;
      fs_d_r <= 1'b0;
    end else begin
      req_s1_r <= req_r;
      req_s2_r <= req_s1_r;
      lk_ack_r <= req_s2_r;
      fs_s1_r <= fsync;
      fs_s2_r <= fs_s1_r;
      fs_d_r <= fs_s2_r;
    end
  end
  wire new_bundle = req_s2_r != lk_ack_r;

  // ---------------------------------------------------------------
  // frame tracking
  // ---------------------------------------------------------------
  atm_fmt_t fmt_l_r;
  wire fs_rise = fs_s2_r && !fs_d_r;
  wire fs_fall = !fs_s2_r && fs_d_r;
  wire is_i2s = fmt_l_r == ATM_FMT_I2S;
  wire is_tdm = fmt_l_r == ATM_FMT_TDM;
  wire frame_start = is_i2s ? fs_fall : fs_rise;
  wire half_start = !is_tdm && (is_i2s ? fs_rise : fs_fall);
  logic started_r, skip_r, half_r;
  logic [5:0] slot_cnt_r;
  logic [CW-1:0] bit_cnt_r;
  wire [5:0] slot_lim = is_tdm ? ATM_TDM_SLOTS : ATM_HALF_SLOTS;
  wire in_slot = started_r && !skip_r && slot_cnt_r < slot_lim;
  wire [4:0] eff_slot = is_tdm ? slot_cnt_r[4:0] : // R3
                        {half_r, slot_cnt_r[3:0]}; // R4 R5
  wire word_end = bit_cnt_r == CW'(WORD_BITS - 1);

  always_ff @(posedge bclk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      started_r <= 1'b0;
      skip_r <= 1'b0;
      half_r <= 1'b0;
      slot_cnt_r <= '0;
      bit_cnt_r <= '0;
    end else if (frame_start || half_start) begin
      started_r <= 1'b1;
      skip_r <= is_i2s; // one bclk of delay in i2s
      half_r <= half_start;
      slot_cnt_r <= '0;
      bit_cnt_r <= '0;
    end else if (skip_r) begin
      skip_r <= 1'b0;
    end else if (in_slot) begin
      bit_cnt_r <= word_end ? '0 : bit_cnt_r + 1'b1;
      if (word_end) slot_cnt_r <= slot_cnt_r + 6'h01;
    end
  end

  // ---------------------------------------------------------------
  // pending and active bundle, committed at frame start
  // ---------------------------------------------------------------
  logic [WORD_BITS-1:0] pend_smp_r [ATM_NUM_CH];
  logic [WORD_BITS-1:0] smp_l_r [ATM_NUM_CH];
  logic [ATM_CFG_BITS-1:0] pend_cfg_r [ATM_NUM_CH];
  logic [ATM_CFG_BITS-1:0] cfg_l_r [ATM_NUM_CH];
  logic [ATM_NUM_CH-1:0] pend_sel_r, sel_l_r;
  logic pend_fill_r, fill_l_r;
  atm_fmt_t pend_fmt_r;

  always_ff @(posedge bclk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      pend_smp_r[0] <= '0;
      pend_smp_r[1] <= '0;
      pend_cfg_r[0] <= ATM_RST_CH_ONE[ATM_CFG_BITS-1:0];
      pend_cfg_r[1] <= ATM_RST_CH_TWO[ATM_CFG_BITS-1:0];
      pend_sel_r <= '0;
      pend_fill_r <= 1'b0;
      pend_fmt_r <= ATM_FMT_TDM;
    end else if (new_bundle) begin
      pend_smp_r[0] <= hold_smp_r[0];
      pend_smp_r[1] <= hold_smp_r[1];
      pend_cfg_r[0] <= hold_cfg_r[0];
      pend_cfg_r[1] <= hold_cfg_r[1];
      pend_sel_r <= hold_sel_r;
      pend_fill_r <= hold_fill_r;
      pend_fmt_r <= hold_fmt_r;
    end
  end

  // format is also taken before the first frame starts so the very first frame is seen
  wire commit = frame_start || !started_r;
  always_ff @(posedge bclk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      smp_l_r[0] <= '0;
      smp_l_r[1] <= '0;
      cfg_l_r[0] <= ATM_RST_CH_ONE[ATM_CFG_BITS-1:0];
      cfg_l_r[1] <= ATM_RST_CH_TWO[ATM_CFG_BITS-1:0];
      sel_l_r <= '0;
      fill_l_r <= 1'b0;
      fmt_l_r <= ATM_FMT_TDM;
    end else if (commit) begin
      smp_l_r[0] <= pend_smp_r[0];
      smp_l_r[1] <= pend_smp_r[1];
      cfg_l_r[0] <= pend_cfg_r[0];
      cfg_l_r[1] <= pend_cfg_r[1];
      sel_l_r <= pend_sel_r;
      fill_l_r <= pend_fill_r;
      fmt_l_r <= pend_fmt_r;
    end
  end

  // ---------------------------------------------------------------
  // per-channel slot match and pin routing
  // ---------------------------------------------------------------
  wire [CW-1:0] bit_idx = CW'(WORD_BITS - 1) - bit_cnt_r;
  logic [ATM_NUM_CH-1:0] ch_hit, ch_act, ch_bit;
  logic [ATM_NUM_CH-1:0] on_pri_act, on_sec_act, on_pri_off, on_sec_off;
  for (genvar c = 0; c < ATM_NUM_CH; c++) begin : g_ch
    assign ch_hit[c] = in_slot &&
      cfg_l_r[c][ATM_SLOT_MSB:ATM_SLOT_LSB] == eff_slot; // R3 R4 R5
    assign ch_act[c] = ch_hit[c] && cfg_l_r[c][ATM_ENA_BIT]; // R1 R2
    assign ch_bit[c] = smp_l_r[c][bit_idx];
    assign on_pri_act[c] = ch_act[c] && !sel_l_r[c]; // R9
    assign on_sec_act[c] = ch_act[c] && sel_l_r[c]; // R9
    assign on_pri_off[c] = ch_hit[c] && !ch_act[c] && !sel_l_r[c];
    assign on_sec_off[c] = ch_hit[c] && !ch_act[c] && sel_l_r[c];
  end

  // channel one wins if both channels are enabled on the same pin and slot
  wire pri_bit = on_pri_act[0] ? ch_bit[0] : ch_bit[1];
  wire sec_bit = on_sec_act[0] ? ch_bit[0] : ch_bit[1];
  wire pri_drv = |on_pri_act;
  wire sec_drv = |on_sec_act;
  wire pri_hiz = !pri_drv && (|on_pri_off || fill_l_r); // R1 R2 R10
  wire sec_hiz = !sec_drv && (|on_sec_off || fill_l_r); // R1 R2 R10

  always_ff @(posedge bclk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      primary_serial_out <= 1'b0;
      primary_serial_oe_n <= 1'b0;
      secondary_serial_out <= 1'b0;
      secondary_serial_oe_n <= 1'b0;
    end else begin
      primary_serial_out <= pri_drv && pri_bit; // R10
      primary_serial_oe_n <= pri_hiz;
      secondary_serial_out <= sec_drv && sec_bit; // R10
      secondary_serial_oe_n <= sec_hiz;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic first_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) first_r <= 1'b1;
    else first_r <= 1'b0;
  end

  sequence s_write_one;
    reg_wr && hit_one && !reg_rd;
  endsequence
  sequence s_read_one;
    reg_rd && hit_one && !reg_wr;
  endsequence

  a_reset_ch_one: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
    first_r |-> cfg_r[0] == ATM_RST_CH_ONE[ATM_CFG_BITS-1:0])
    else $error("channel one config not at reset value");
  a_reset_ch_two: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
    first_r |-> cfg_r[1] == ATM_RST_CH_TWO[ATM_CFG_BITS-1:0])
    else $error("channel two config not at reset value");
  a_rsvd_read_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
    s_write_one ##1 !reg_wr ##1 s_read_one |=> reg_rvalid &&
      reg_rdata == {ATM_RSVD_VAL, $past(reg_wdata[ATM_CFG_BITS-1:0], 3)})
    else $error("config read back wrong or reserved bits set");
  a_pri_drive_one: assert property (@(posedge bclk) disable iff (!lrst_n_r) // R1
    on_pri_act[0] |=> !primary_serial_oe_n &&
      primary_serial_out == $past(ch_bit[0]))
    else $error("channel one not driven on primary pin in its slot");
  a_pri_off_two: assert property (@(posedge bclk) disable iff (!lrst_n_r) // R2
    (ch_hit[1] && !cfg_l_r[1][ATM_ENA_BIT] && !sel_l_r[1] && !on_pri_act[0])
      |=> primary_serial_oe_n)
    else $error("disabled channel two slot not tri-stated");
  a_sec_route: assert property (@(posedge bclk) disable iff (!lrst_n_r) // R9
    (ch_act[1] && sel_l_r[1] && !on_sec_act[0]) |=>
      !secondary_serial_oe_n && secondary_serial_out == $past(ch_bit[1]))
    else $error("channel two not routed to secondary pin");
  a_fill_zero: assert property (@(posedge bclk) disable iff (!lrst_n_r) // R10
    (!in_slot && !fill_l_r) |=> !primary_serial_oe_n && !primary_serial_out
      && !secondary_serial_oe_n && !secondary_serial_out)
    else $error("unused cycle not driven low");
  a_fill_hiz: assert property (@(posedge bclk) disable iff (!lrst_n_r) // R10
    (!in_slot && fill_l_r) |=> primary_serial_oe_n && secondary_serial_oe_n)
    else $error("unused cycle not high impedance");
  a_right_half: assert property (@(posedge bclk) disable iff (!lrst_n_r) // R5
    (!is_tdm && half_start) |=> half_r && eff_slot[4])
    else $error("right half slot not above fifteen");
  a_tdm_slot: assert property (@(posedge bclk) disable iff (!lrst_n_r) // R3
    (is_tdm && in_slot && word_end && slot_cnt_r < 6'h1f && !frame_start)
      |=> eff_slot == $past(eff_slot) + 5'h01)
    else $error("tdm slot did not advance after a word");
endmodule // atm_slot_mapper

// file: dv/atm_host_port.sv
// behavioural host audio port: bit clock, frame sync and frame bit counter
`timescale 1ns/100ps
module atm_host_port #(
  parameter int FRAME_BITS = 512
) (
  input wire atm_pkg::atm_fmt_t frame_format,
  output logic bclk,
  output logic fsync,
  output logic [9:0] bit_cnt
);
  import atm_pkg::*;
  // ---------------------------------------------------------------
  // bit clock, free running, phase unrelated to core_clk
  // ---------------------------------------------------------------
  initial begin
    bclk = 1'b0;
    bit_cnt = 10'h0;
    #37;
    forever #62.5 bclk = ~bclk;
  end
  // ---------------------------------------------------------------
  // frame timing, changes only after a falling bit clock edge
  // ---------------------------------------------------------------
  always @(negedge bclk) begin
    bit_cnt <= (bit_cnt == 10'(FRAME_BITS - 1)) ? 10'h0 : bit_cnt + 10'h1;
  end
  // tdm one-cycle pulse, lj high on left half, i2s low on left half
  always_comb begin
    case (frame_format)
      ATM_FMT_TDM: fsync = (bit_cnt == 10'h0);
      ATM_FMT_LJ: fsync = (bit_cnt < 10'(FRAME_BITS / 2));
      default: fsync = (bit_cnt >= 10'(FRAME_BITS / 2));
    endcase
  end
endmodule // atm_host_port

// file: dv/tb_top.sv
// self-checking bench for the transmit channel slot mapper
`timescale 1ns/100ps
module tb_top;
  import atm_pkg::*;
  localparam int W = 16;
  localparam int F = 512;
  localparam int HALF = 256;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic core_clk, rst_n, reg_wr, reg_rd, reg_rvalid, sample_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic sel1, sel2, fill, sample_ready, bclk, fsync;
  logic p_out, p_oe_n, s_out, s_oe_n;
  logic [W-1:0] s1, s2;
  logic [9:0] bit_cnt;
  logic [7:0] cfg1, cfg2, d;
  logic [31:0] seed, r;
  atm_fmt_t fmt, pf;
  int fail_count, compares, c;
  // hand-made corner cases first, random ones after
  logic [7:0] t1 [5] = '{8'h20, 8'h03, 8'h3f, 8'h30, 8'h20};
  logic [7:0] t2 [5] = '{8'h21, 8'h23, 8'h05, 8'h2f, 8'h31};
  logic [1:0] tf [5] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h1};
  logic [2:0] ts [5] = '{3'h0, 3'h4, 3'h1, 3'h4, 3'h2};
  atm_slot_mapper #(.WORD_BITS(W)) dut_u (.core_clk(core_clk),
    .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .tx_chan_one_pin_select(sel1), .tx_chan_two_pin_select(sel2),
    .tx_unused_cycle_fill(fill), .frame_format(fmt),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .chan_one_sample(s1), .chan_two_sample(s2), .bclk(bclk),
    .fsync(fsync), .primary_serial_out(p_out),
    .primary_serial_oe_n(p_oe_n), .secondary_serial_out(s_out),
    .secondary_serial_oe_n(s_oe_n));
  atm_host_port #(.FRAME_BITS(F)) host_u (.frame_format(fmt),
    .bclk(bclk), .fsync(fsync), .bit_cnt(bit_cnt));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic stop_test();
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    // rvalid and rdata stand for one cycle only, take them now
    check("read valid", {7'h0, reg_rvalid}, 8'h01);
    v = reg_rdata;
    reg_rd = 1'b0;
  endtask
  // {oe_n, out} expected on a pin for frame cycle k
  function automatic logic [1:0] exp_pin(input logic pin, input int k);
    int pos, slot, b;
    logic h1, h2;
    pos = k - ((fmt == ATM_FMT_I2S) ? 4 : 3);
    if (fmt == ATM_FMT_TDM) slot = pos / W;
    else slot = (pos % HALF) / W + ((pos >= HALF) ? 16 : 0);
    b = W - 1 - (pos % W);
    h1 = (sel1 == pin) && (cfg1[4:0] == slot[4:0]);
    h2 = (sel2 == pin) && (cfg2[4:0] == slot[4:0]);
    if (h1 && cfg1[5]) return {1'b0, s1[b]};
    if (h2 && cfg2[5]) return {1'b0, s2[b]};
    if (h1 || h2) return 2'b10;
    return fill ? 2'b10 : 2'b00;
  endfunction
  task automatic send_bundle();
    int n;
    @(negedge core_clk);
    sample_valid = 1'b1;
    @(negedge core_clk);
    sample_valid = 1'b0;
    n = 0;
    while (sample_ready !== 1'b1) begin
      @(negedge core_clk);
      n++;
      if (n > 2000) begin
        fail_count++;
        stop_test();
      end
    end
  endtask
  // a format change needs one whole frame before the link follows it
  task automatic check_frame(input logic twice);
    int n;
    logic [1:0] e;
    n = 0;
    repeat (twice ? 2 : 1) begin
      do begin
        @(negedge bclk);
        n++;
        if (n > 3 * F) begin
          fail_count++;
          stop_test();
        end
      end while (bit_cnt !== 10'(F - 1));
    end
    for (int k = 0; k < F; k++) begin
      @(negedge bclk);
      if (k >= 4 || (k == 3 && fmt != ATM_FMT_I2S)) begin
        e = exp_pin(1'b0, k);
        check("primary pin", {6'h0, p_oe_n, e[1] ? 1'b0 : p_out}, {6'h0, e});
        e = exp_pin(1'b1, k);
        check("secondary pin", {6'h0, s_oe_n, e[1] ? 1'b0 : s_out}, {6'h0, e});
      end
    end
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h23850e65;
    {reg_wr, reg_rd, sample_valid, sel1, sel2, fill} = 6'h0;
    {reg_addr, reg_wdata} = 16'h0;
    {s1, s2} = '0;
    fmt = ATM_FMT_TDM;
    fail_count = 0;
    compares = 0;
    // held long enough for the link domain to see bit clock edges
    rst_n = 1'b0;
    repeat (40) @(negedge core_clk);
    rst_n = 1'b1;
    reg_read(ATM_ADDR_CH_ONE, d);
    check("chan one reset", d, ATM_RST_CH_ONE);
    reg_read(ATM_ADDR_CH_TWO, d);
    check("chan two reset", d, ATM_RST_CH_TWO);
    reg_read(8'h1d, d);
    check("unmapped read", d, 8'h00);
    for (c = 0; c < 8; c++) begin
      r = rnd();
      s1 = r[W-1:0];
      s2 = r[31:32-W];
      r = rnd();
      pf = fmt;
      if (c < 5) begin
        cfg1 = t1[c];
        cfg2 = t2[c];
        fmt = atm_fmt_t'(tf[c]);
        {fill, sel2, sel1} = ts[c];
      end else begin
        cfg1 = {2'h0, r[5:0]};
        cfg2 = {2'h0, r[13:8]};
        fmt = atm_fmt_t'((c + 2) % 3);
        {fill, sel2, sel1} = r[18:16];
        // i2s cuts the last slot of a half for the skip cycle
        if (fmt == ATM_FMT_I2S) cfg1[0] = 1'b0;
        if (fmt == ATM_FMT_I2S) cfg2[0] = 1'b0;
      end
      if (c > 0) begin
        reg_write(ATM_ADDR_CH_ONE, cfg1);
        reg_read(ATM_ADDR_CH_ONE, d);
        check("chan one config", d, cfg1);
        reg_write(ATM_ADDR_CH_TWO, cfg2);
        reg_read(ATM_ADDR_CH_TWO, d);
        check("chan two config", d, cfg2);
      end
      send_bundle();
      check_frame(fmt != pf);
    end
    stop_test();
  end
endmodule // tb_top
